// >>> rtl/rfrm_regbank.sv
// register bank and command dispatch of the reader frontend
//
// Overview of operation
// - receive protocol number selects speed and coding
// - transmit protocol number selects speed and coding
// - random fill pushes bytes until queue full
// - code 1Fh starts default reload sequence
// - reload copies all defaults from nvm
// - read-write bits never changed by hardware
// - dynamic bits host writable and hardware updated
// - finished command clears command field itself
// - host writes to read-only bits ignored
// - write-only bits always read zero
// - decode command to queue data at 00h-05h
// - interrupt requests 06h-07h, enables 08h-09h
// - errors at 0Ah, status at 0Bh
// - anticollision control 0Ch, collision 0Dh
// - timer common 0Eh, timer a 0Fh-13h
// - command field bits 4..0 show command
// - idle command cancels running command, except the default reload
// - protocol load fetches protocol area settings
`timescale 1ns/1ps
`default_nettype none
module rfrm_regbank (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // host register access
  input wire rfrm_pkg::rfrm_host_req_t hreq,
  output logic [7:0] rdata,
  output logic rvalid,
  // hardware state in
  input wire rfrm_pkg::rfrm_hw_t hw,
  // queue side
  input wire logic [7:0] fifo_level,
  input wire logic fifo_full,
  input wire logic [7:0] fifo_rdata,
  output logic fifo_push,
  output logic [7:0] fifo_wdata,
  output logic fifo_pop,
  output logic fifo_flush,
  // random source
  input wire logic [7:0] rng_byte,
  // non-volatile memory read port
  output logic nvm_rd,
  output logic [7:0] nvm_addr,
  input wire logic nvm_rvalid,
  input wire logic [7:0] nvm_rdata,
  // external command executor
  output logic [4:0] cmd_code,
  output logic cmd_start,
  input wire logic cmd_done,
  // register contents for the rest of the device
  output logic [0:0] unused_none,
  output var rfrm_pkg::rfrm_proto_t proto,
  output logic [15:0] timer_a_reload,
  output logic standby,
  output logic modem_off
);
  import rfrm_pkg::*;
  localparam int unsigned NREG_OUT = 1;

  // ======================================================================
  // storage and state
  logic [NREG-1:0][7:0] regs;
  logic [NREG-1:0][7:0] next_regs;
  rfrm_state_t state;
  rfrm_state_t next_state;
  logic [4:0] idx;
  logic nvm_pend;
  logic [2:0] rx_num, tx_num;
  logic [7:0] rx_cfg, tx_cfg;

  // ======================================================================
  // host decode
  wire host_wr = hreq.wr;
  wire host_rd = hreq.rd;
  wire cmd_wr = host_wr && (hreq.addr == A_CMD);
  wire [4:0] new_cmd = hreq.wdata[4:0];
  wire idle_wr = cmd_wr && (new_cmd == CMD_IDLE);
  wire data_wr = host_wr && (hreq.addr == A_QDATA);
  wire data_rd = host_rd && (hreq.addr == A_QDATA);
  // the default reload owns the register set, host register writes during it are dropped; queue data writes and flushes still act
  wire in_reload = (state == RFRM_SRST);
  wire nvm_take = nvm_pend && nvm_rvalid;
  wire last_reg = (idx == 5'(NREG - 1));

  // ======================================================================
  // per register next value: reload, host merge, then hardware updates
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      wire hit = host_wr && !in_reload && (hreq.addr == 7'(gi));
      wire [7:0] merged = (regs[gi] & ~WMASK[gi]) | (hreq.wdata & WMASK[gi]);
      wire [7:0] hw_set = (gi == int'(A_IRQA)) ? hw.irq_set_a :
                          (gi == int'(A_IRQB)) ? hw.irq_set_b : 8'h00;
      wire [7:0] hw_clr = (gi == int'(A_CMD) && hw.wake) ? 8'h80 : 8'h00;
      wire load = in_reload && nvm_take && (idx == 5'(gi));
      // set after host merge so an event in the clearing cycle survives
      assign next_regs[gi] = load ? (nvm_rdata & WMASK[gi]) :
                             (((hit ? merged : regs[gi]) & ~hw_clr) | hw_set);
    end
  endgenerate

  // ======================================================================
  // register file
  always_ff @(posedge clk) begin
    if (!nrst) begin
      regs <= RESET_VAL;
    end else if (ce) begin
      regs <= next_regs;
    end
  end

  // ======================================================================
  // command sequencing
  always_comb begin
    next_state = state;
    case (state)
      RFRM_IDLE: begin
        if (cmd_wr) begin
          case (new_cmd)
            CMD_IDLE: next_state = RFRM_IDLE;
            CMD_RANDOM_FILL: next_state = RFRM_RFILL;
            CMD_DEFAULT_RELOAD: next_state = RFRM_SRST;
            CMD_PROTO_LOAD: next_state = (fifo_level < 8'h02) ? RFRM_IDLE : RFRM_PPOP;
            default: next_state = RFRM_EXT;
          endcase
        end
      end
      RFRM_RFILL: begin
        if (fifo_full || idle_wr) begin
          next_state = RFRM_IDLE;
        end
      end
      RFRM_SRST: begin
        if (nvm_take && last_reg) begin
          next_state = RFRM_IDLE;
        end
      end
      RFRM_PPOP: begin
        if (idle_wr) begin
          next_state = RFRM_IDLE;
        end else if (idx[0]) begin
          next_state = RFRM_PNVM;
        end
      end
      RFRM_PNVM: begin
        if (idle_wr || (nvm_take && idx[0])) begin
          next_state = RFRM_IDLE;
        end
      end
      RFRM_EXT: begin
        if (cmd_done || idle_wr) begin
          next_state = RFRM_IDLE;
        end
      end
      default: next_state = RFRM_IDLE;
    endcase
  end

  // the reload cannot be cancelled: a half loaded register set is worse
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= RFRM_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ======================================================================
  // command field follows execution and drops to idle when done
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_code <= CMD_IDLE;
    end else if (ce) begin
      if (next_state == RFRM_IDLE) begin
        cmd_code <= CMD_IDLE;
      end else if (state == RFRM_IDLE && cmd_wr) begin
        cmd_code <= new_cmd;
      end
    end
  end

  // ======================================================================
  // sequence index and nvm handshake
  wire idx_step = ((state == RFRM_SRST || state == RFRM_PNVM) && nvm_take) ||
                  (state == RFRM_PPOP);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      idx <= 5'h00;
      nvm_pend <= 1'b0;
    end else if (ce) begin
      if (next_state != state || state == RFRM_IDLE) begin
        idx <= 5'h00;
      end else if (idx_step) begin
        idx <= idx + 5'h01;
      end
      if (nvm_rd) begin
        nvm_pend <= 1'b1;
      end else if (nvm_rvalid || next_state == RFRM_IDLE) begin
        nvm_pend <= 1'b0;
      end
    end
  end

  // one read outstanding at a time, address from the walk index in the reload, from the protocol numbers in the load
  assign nvm_rd = ce && !nvm_pend && (state == RFRM_SRST ||
                  (state == RFRM_PNVM && !idle_wr && idx < 5'h02));
  assign nvm_addr = (state == RFRM_SRST) ? NVM_DEFAULTS_BASE + {3'h0, idx} :
                    idx[0] ? NVM_PROTO_TX_BASE + {5'h00, tx_num} :
                    NVM_PROTO_RX_BASE + {5'h00, rx_num};

  // ======================================================================
  // protocol numbers from the queue, settings from the protocol area
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_num <= 3'h0;
      tx_num <= 3'h0;
      rx_cfg <= 8'h00;
      tx_cfg <= 8'h00;
    end else if (ce) begin
      if (state == RFRM_PPOP && !idx[0]) begin
        rx_num <= fifo_rdata[2:0];
      end
      if (state == RFRM_PPOP && idx[0]) begin
        tx_num <= fifo_rdata[2:0];
      end
      if (state == RFRM_PNVM && nvm_take) begin
        if (idx[0]) begin
          tx_cfg <= nvm_rdata;
        end else begin
          rx_cfg <= nvm_rdata;
        end
      end
    end
  end

  // ======================================================================
  // predefined protocol tables
  wire [9:0] rx_kbps = (rx_num == 3'h1) ? 10'd52 :
                       (rx_num == 3'h4 || rx_num == 3'h7) ? 10'd212 :
                       (rx_num == 3'h5) ? 10'd106 :
                       (rx_num == 3'h6) ? 10'd424 : 10'd26;
  wire [2:0] rx_coding = (rx_num == 3'h2) ? RXC_DSC :
                         (rx_num == 3'h4) ? RXC_2_424 :
                         (rx_num == 3'h5) ? RXC_4_424 :
                         (rx_num == 3'h6) ? RXC_2_848 :
                         (rx_num == 3'h7) ? RXC_4_848 : RXC_SSC;
  wire [12:0] tx_rate = (tx_num < 3'h2) ? 13'd2600 :
                        (tx_num == 3'h2) ? 13'd166 :
                        (tx_num == 3'h3) ? 13'd5300 : 13'd0;
  wire [1:0] tx_coding = (tx_num < 3'h2) ? TXC_1OF4 :
                         (tx_num == 3'h2) ? TXC_1OF256 :
                         (tx_num == 3'h3) ? TXC_UNITARY : TXC_ASK_PIE;
  assign proto = '{rx_num: rx_num, rx_kbps: rx_kbps, rx_coding: rx_coding,
                   tx_num: tx_num, tx_rate: tx_rate, tx_coding: tx_coding,
                   rx_cfg: rx_cfg, tx_cfg: tx_cfg};

  // ======================================================================
  // queue strobes: random fill stops on full, host and load pop by port
  wire rfill_go = (state == RFRM_RFILL) && !fifo_full && !idle_wr;
  assign fifo_push = ce && (rfill_go || data_wr);
  assign fifo_wdata = rfill_go ? rng_byte : hreq.wdata;
  assign fifo_pop = ce && (data_rd || state == RFRM_PPOP);
  assign fifo_flush = ce && host_wr && (hreq.addr == A_QCTL) && hreq.wdata[QCTL_FLUSH];
  assign cmd_start = ce && (state == RFRM_IDLE) && (next_state == RFRM_EXT);
  assign unused_none = '0;

  // ======================================================================
  // read decode; write-only and reserved bits come back as zero
  wire [7:0] cmd_view = {regs[A_CMD][7:6], 1'b0, cmd_code};
  wire [7:0] rd_mux =
    (hreq.addr == A_CMD) ? cmd_view :
    (hreq.addr == A_QCTL) ? (regs[A_QCTL] & ~(8'h01 << QCTL_FLUSH)) :
    (hreq.addr == A_QCNT) ? fifo_level :
    (hreq.addr == A_QDATA) ? fifo_rdata :
    (hreq.addr == A_ERR) ? hw.errors :
    (hreq.addr == A_STAT) ? hw.status :
    (hreq.addr == A_CPOS) ? hw.coll_pos :
    (hreq.addr == A_TCNH) ? hw.timer_count[15:8] :
    (hreq.addr == A_TCNL) ? hw.timer_count[7:0] :
    (hreq.addr < 7'(NREG)) ? regs[hreq.addr[4:0]] : 8'h00;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else if (ce) begin
      rvalid <= host_rd;
      if (host_rd) begin
        rdata <= rd_mux;
      end
    end
  end

  assign timer_a_reload = {regs[A_TRLH], regs[A_TRLL]};
  assign standby = regs[A_CMD][CMD_STANDBY];
  assign modem_off = regs[A_CMD][CMD_MODEM_OFF];

  // ======================================================================
  // checks
  a_idle_cancels: assert property (@(posedge clk) disable iff (!nrst)
    ce && idle_wr && state != RFRM_SRST |=> state == RFRM_IDLE && cmd_code == CMD_IDLE)
    else $error("idle write did not cancel command");
  a_fill_stops_full: assert property (@(posedge clk) disable iff (!nrst)
    state == RFRM_RFILL && fifo_full |-> !fifo_push)
    else $error("random fill pushed into a full queue");
  a_fill_done_clr: assert property (@(posedge clk) disable iff (!nrst)
    ce && state == RFRM_RFILL && fifo_full |=> cmd_code == CMD_IDLE)
    else $error("command field not cleared after random fill");
  a_reload_start: assert property (@(posedge clk) disable iff (!nrst)
    ce && state == RFRM_IDLE && cmd_wr && new_cmd == CMD_DEFAULT_RELOAD
    |=> state == RFRM_SRST ##0 nvm_rd)
    else $error("default reload did not start");
  a_reload_copies: assert property (@(posedge clk) disable iff (!nrst)
    ce && in_reload && nvm_take && idx == 5'(A_QWARN) |=> regs[A_QWARN] == $past(nvm_rdata))
    else $error("reload value not stored");
  a_wo_reads_zero: assert property (@(posedge clk) disable iff (!nrst)
    ce && host_rd && hreq.addr == A_QCTL |=> !rdata[QCTL_FLUSH])
    else $error("write-only bit read back nonzero");
  a_rw_stable: assert property (@(posedge clk) disable iff (!nrst)
    ce && !in_reload && !(host_wr && hreq.addr == A_ACOL) |=> $stable(regs[A_ACOL]))
    else $error("read-write register changed by hardware");
  a_fill_count_read: assert property (@(posedge clk) disable iff (!nrst)
    ce && host_rd && hreq.addr == A_QCNT |=> rvalid && rdata == $past(fifo_level))
    else $error("fill count read wrong");
  a_error_read: assert property (@(posedge clk) disable iff (!nrst)
    ce && host_rd && hreq.addr == A_ERR |=> rdata == $past(hw.errors))
    else $error("error register read wrong");
  a_rx_table: assert property (@(posedge clk) disable iff (!nrst)
    rx_num == 3'h6 |-> proto.rx_kbps == 10'd424 && proto.rx_coding == RXC_2_848)
    else $error("receive protocol table wrong");
  a_tx_table: assert property (@(posedge clk) disable iff (!nrst)
    tx_num == 3'h2 |-> proto.tx_rate == 13'd166 && proto.tx_coding == TXC_1OF256)
    else $error("transmit protocol table wrong");
  c_fill_run: cover property (@(posedge clk) state == RFRM_RFILL ##1 fifo_full);
  c_reload_end: cover property (@(posedge clk) in_reload && nvm_take && last_reg);
  c_proto_load: cover property (@(posedge clk) state == RFRM_PNVM && nvm_take && idx[0]);
endmodule // rfrm_regbank
`default_nettype wire

// >>> common/rfrm_pkg.sv
// constants and types for the reader frontend register bank
package rfrm_pkg;
  // ======================================================================
  // address map
  localparam int unsigned NREG = 20;
  localparam logic [6:0] A_CMD = 7'h00, A_HOST = 7'h01, A_QCTL = 7'h02, A_QWARN = 7'h03;
  localparam logic [6:0] A_QCNT = 7'h04, A_QDATA = 7'h05, A_IRQA = 7'h06, A_IRQB = 7'h07;
  localparam logic [6:0] A_IENA = 7'h08, A_IENB = 7'h09, A_ERR = 7'h0a, A_STAT = 7'h0b;
  localparam logic [6:0] A_ACOL = 7'h0c, A_CPOS = 7'h0d, A_TCOM = 7'h0e, A_TCTL = 7'h0f;
  localparam logic [6:0] A_TRLH = 7'h10, A_TRLL = 7'h11, A_TCNH = 7'h12, A_TCNL = 7'h13;
  // ======================================================================
  // bit classes: host-writable stored bits per address, index 0 at the right
  localparam logic [NREG-1:0][7:0] WMASK = {
    8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hef, 8'hec, 8'hc0};
  localparam logic [NREG-1:0][7:0] RESET_VAL = '0;
  localparam int unsigned CMD_STANDBY = 7, CMD_MODEM_OFF = 6;
  localparam int unsigned QCTL_FLUSH = 4; // write-only, reads zero
  // ======================================================================
  // commands and non-volatile memory layout
  localparam logic [4:0] CMD_IDLE = 5'h00, CMD_PROTO_LOAD = 5'h0d;
  localparam logic [4:0] CMD_RANDOM_FILL = 5'h1c, CMD_DEFAULT_RELOAD = 5'h1f;
  localparam logic [7:0] NVM_DEFAULTS_BASE = 8'h00, NVM_PROTO_RX_BASE = 8'h40;
  localparam logic [7:0] NVM_PROTO_TX_BASE = 8'h48;
  // ======================================================================
  // protocol setting codes
  localparam logic [2:0] RXC_SSC = 3'h0, RXC_DSC = 3'h1, RXC_2_424 = 3'h2;
  localparam logic [2:0] RXC_4_424 = 3'h3, RXC_2_848 = 3'h4, RXC_4_848 = 3'h5;
  localparam logic [1:0] TXC_1OF4 = 2'h0, TXC_1OF256 = 2'h1, TXC_UNITARY = 2'h2;
  localparam logic [1:0] TXC_ASK_PIE = 2'h3;
  // ======================================================================
  typedef enum logic [5:0] {
    RFRM_IDLE = 6'b000001, RFRM_RFILL = 6'b000010, RFRM_SRST = 6'b000100,
    RFRM_PPOP = 6'b001000, RFRM_PNVM = 6'b010000, RFRM_EXT = 6'b100000
  } rfrm_state_t;
  typedef struct packed {
    logic [6:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rfrm_host_req_t;
  typedef struct packed {
    logic [7:0] errors;
    logic [7:0] status;
    logic [7:0] coll_pos;
    logic [15:0] timer_count;
    logic [7:0] irq_set_a;
    logic [7:0] irq_set_b;
    logic wake;
  } rfrm_hw_t;
  typedef struct packed {
    logic [2:0] rx_num;
    logic [9:0] rx_kbps;          // kbit/s
    logic [2:0] rx_coding;
    logic [2:0] tx_num;
    logic [12:0] tx_rate;         // hundredths of kbit/s, zero: Tari based
    logic [1:0] tx_coding;
    logic [7:0] rx_cfg;
    logic [7:0] tx_cfg;
  } rfrm_proto_t;
endpackage

// >>> test/rfrm_far_model.sv
// far-side model of the register bank: byte queue and non-volatile memory
`timescale 1ns/1ps
`default_nettype none
module rfrm_far_model #(parameter int DEPTH = 6) (
  // clock
  input wire logic clk,
  // queue side
  input wire logic fifo_push,
  input wire logic [7:0] fifo_wdata,
  input wire logic fifo_pop,
  input wire logic fifo_flush,
  output logic [7:0] fifo_level,
  output logic fifo_full,
  output logic [7:0] fifo_rdata,
  // memory side
  input wire logic nvm_rd,
  input wire logic [7:0] nvm_addr,
  output logic nvm_rvalid,
  output logic [7:0] nvm_rdata
);
  logic [7:0] mem [16];
  logic [3:0] wp = 4'h0, rp = 4'h0;
  logic [7:0] cnt = 8'h00, addr_q = 8'h00;
  logic [1:0] wait_cnt = 2'h0;
  logic busy = 1'b0, slow = 1'b0;
  initial nvm_rvalid = 1'b0;
  initial nvm_rdata = 8'h00;
  // an empty queue shows the inverted head slot, never the last byte
  assign fifo_level = cnt;
  assign fifo_full = cnt >= 8'(DEPTH);
  assign fifo_rdata = (cnt != 8'h00) ? mem[rp] : ~mem[rp];
  // preload used by the bench for command parameters
  task automatic put(input logic [7:0] b);
    mem[wp] = b;
    wp = wp + 4'h1;
    cnt = cnt + 8'h01;
  endtask
  // queue update; flush wins over push and pop
  always @(posedge clk) begin
    if (fifo_flush) begin
      rp <= wp;
      cnt <= 8'h00;
    end else begin
      if (fifo_push && !fifo_full) begin
        mem[wp] <= fifo_wdata;
        wp <= wp + 4'h1;
      end
      if (fifo_pop && cnt != 8'h00) rp <= rp + 4'h1;
      cnt <= cnt + 8'(fifo_push && !fifo_full) - 8'(fifo_pop && cnt != 8'h00);
    end
  end
  // memory answers alternately fast and slow; data inverts when not valid
  always @(posedge clk) begin
    nvm_rvalid <= 1'b0;
    nvm_rdata <= ~nvm_rdata;
    if (nvm_rd) begin
      addr_q <= nvm_addr;
      wait_cnt <= slow ? 2'h2 : 2'h0;
      slow <= !slow;
      busy <= 1'b1;
    end else if (busy && wait_cnt == 2'h0) begin
      nvm_rvalid <= 1'b1;
      nvm_rdata <= addr_q ^ 8'h5a;
      busy <= 1'b0;
    end else if (busy) begin
      wait_cnt <= wait_cnt - 2'h1;
    end
  end
endmodule // rfrm_far_model
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench of the reader frontend register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rfrm_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, cmd_done = 1'b0;
  rfrm_host_req_t hreq = '0;
  rfrm_hw_t hw = '0;
  logic [7:0] rng_byte = 8'h00, d, rdata, fifo_level, fifo_rdata, fifo_wdata, nvm_addr, nvm_rdata;
  logic rvalid, fifo_full, fifo_push, fifo_pop, fifo_flush, nvm_rd, nvm_rvalid;
  logic cmd_start, standby, modem_off;
  logic [4:0] cmd_code;
  rfrm_proto_t proto;
  logic [15:0] timer_a_reload;
  logic [31:0] seed = 32'hf9f81e40, rs = 32'hf9f81e40;
  int miscompares = 0, total_checks = 0;
  logic [7:0] exp_q [$];
  logic [7:0] shadow [20];
  int rxk [8] = '{26, 52, 26, 26, 212, 106, 424, 212};
  int rxc [8] = '{0, 0, 1, 0, 2, 3, 4, 5};
  int txr [8] = '{2600, 2600, 166, 5300, 0, 0, 0, 0};
  int txc [8] = '{0, 0, 1, 2, 3, 3, 3, 3};
  always #50 clk = ~clk;
  rfrm_regbank DUT (.clk, .nrst, .ce, .hreq, .rdata, .rvalid, .hw, .fifo_level, .fifo_full,
    .fifo_rdata, .fifo_push, .fifo_wdata, .fifo_pop, .fifo_flush, .rng_byte, .nvm_rd, .nvm_addr,
    .nvm_rvalid, .nvm_rdata, .cmd_code, .cmd_start, .cmd_done, .unused_none(), .proto,
    .timer_a_reload, .standby, .modem_off);
  rfrm_far_model #(.DEPTH(6)) far (.clk, .fifo_push, .fifo_wdata, .fifo_pop, .fifo_flush,
    .fifo_level, .fifo_full, .fifo_rdata, .nvm_rd, .nvm_addr, .nvm_rvalid, .nvm_rdata);
  // ======================================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // stored host bits; reserved, write-only and command field read zero
  function automatic logic [7:0] keep(input int a);
    case (a)
      0: return 8'hc0;
      1: return 8'hec;
      2: return 8'hef;
      3, 6, 7, 8, 9, 12, 14, 15, 16, 17: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] ro_val(input int a);
    case (a)
      4: return fifo_level;
      10: return hw.errors;
      11: return hw.status;
      13: return hw.coll_pos;
      18: return hw.timer_count[15:8];
      19: return hw.timer_count[7:0];
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one host request per cycle; a read notes its expected answer
  task automatic acc(input logic w, input logic r, input int a, input logic [7:0] dat);
    @(negedge clk);
    hreq <= {7'(a), w, r, dat};
    if (w && a < 20 && a != 0) shadow[a] = dat & keep(a);
    if (r) exp_q.push_back(a < 20 ? shadow[a] | ro_val(a) : 8'h00);
  endtask
  task automatic idle();
    @(negedge clk);
    hreq <= '0;
  endtask
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cmd_code !== 5'h00 && n < lim);
    chk(16'(cmd_code), 16'h0000);
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ======================================================================
  // read answer monitor and random source
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk(16'(rdata), 16'hxxxx);
      else chk(16'(rdata), 16'(exp_q.pop_front()));
    end
    rs = xs(rs);
    rng_byte <= rs[7:0];
  end
  // hang guard, well beyond the expected run
  initial begin
    #(20000 * 100);
    miscompares++;
    wrap_up();
  end
  // ======================================================================
  // main sequence
  initial begin
    for (int i = 0; i < 20; i++) shadow[i] = 8'h00;
    seed = xs(seed);
    hw.errors = seed[7:0];
    hw.status = seed[15:8];
    hw.coll_pos = seed[23:16];
    hw.timer_count = {seed[31:24], seed[11:4]};
    repeat (20) @(negedge clk);
    nrst <= 1'b1;
    // reset values, read-only sources and unmapped reads
    for (int a = 0; a < 24; a++) if (a != 5) acc(0, 1, a, 8'h00);
    // random writes read back at once, including read-only places
    for (int a = 1; a < 20; a++) begin
      seed = xs(seed);
      d = (a == 1) ? seed[7:0] & 8'hec : seed[7:0];
      if (a != 5) acc(1, 0, a, d);
      if (a != 5) acc(0, 1, a, 8'h00);
    end
    idle();
    chk(timer_a_reload, {shadow[16], shadow[17]});
    // hardware sets interrupt request bits on top of host value
    hw.irq_set_a <= 8'h81;
    @(negedge clk) hw.irq_set_a <= 8'h00;
    shadow[6] = shadow[6] | 8'h81;
    acc(0, 1, 6, 8'h00);
    // standby is dynamic, modem off is host only
    acc(1, 0, 0, 8'hc0);
    idle();
    chk(16'({standby, modem_off}), 16'h0003);
    hw.wake <= 1'b1;
    @(negedge clk) hw.wake <= 1'b0;
    @(negedge clk) chk(16'({standby, modem_off}), 16'h0001);
    shadow[0] = 8'h40;
    // random fill until full, then again on a full queue
    acc(1, 0, 0, {3'b010, CMD_RANDOM_FILL});
    idle();
    chk(16'(cmd_code), 16'h001c);
    wait_idle(40);
    chk(16'(fifo_level), 16'h0006);
    acc(1, 0, 0, {3'b010, CMD_RANDOM_FILL});
    idle();
    wait_idle(3);
    chk(16'(fifo_level), 16'h0006);
    // external command: finishes on done, or is cancelled by idle
    acc(1, 0, 0, 8'h47);
    #1 chk(16'(cmd_start), 16'h0001);
    idle();
    chk(16'(cmd_code), 16'h0007);
    cmd_done <= 1'b1;
    @(negedge clk) cmd_done <= 1'b0;
    chk(16'(cmd_code), 16'h0000);
    acc(1, 0, 0, 8'h47);
    acc(1, 0, 0, 8'h40);
    idle();
    chk(16'(cmd_code), 16'h0000);
    // default reload; a host write meanwhile is dropped
    acc(1, 0, 0, {3'b010, CMD_DEFAULT_RELOAD});
    acc(1, 0, 3, 8'h11);
    idle();
    wait_idle(200);
    for (int i = 0; i < 20; i++) shadow[i] = 8'(i ^ 8'h5a) & keep(i);
    for (int a = 0; a < 20; a++) if (a != 5) acc(0, 1, a, 8'h00);
    chk(16'(modem_off), 16'h0001);
    // protocol load over every number, after a flush and one short queue
    acc(1, 0, 2, 8'h10);
    acc(1, 0, 0, {3'b010, CMD_PROTO_LOAD});
    idle();
    wait_idle(3);
    for (int n = 0; n < 8; n++) begin
      far.put(8'(n));
      far.put(8'(7 - n));
      acc(1, 0, 0, {3'b010, CMD_PROTO_LOAD});
      idle();
      wait_idle(40);
      chk(16'({proto.rx_num, proto.tx_num}), 16'({3'(n), 3'(7 - n)}));
      chk(16'(proto.rx_kbps), 16'(rxk[n]));
      chk(16'(proto.rx_coding), 16'(rxc[n]));
      chk(16'(proto.tx_rate), 16'(txr[7 - n]));
      chk(16'(proto.tx_coding), 16'(txc[7 - n]));
      chk({proto.rx_cfg, proto.tx_cfg}, {8'(8'h40 + n) ^ 8'h5a, 8'(8'h4f - n) ^ 8'h5a});
    end
    repeat (3) @(negedge clk);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
